//--- rtl/mbdc_bus_drive.sv
// Bus drive control: address, data and direction drivers, bus released flag
// How it works
// [R1] All sixteen address outputs go high impedance while the float request is high.
// [R2] The eight data lines are three-state and float whenever data drive enable is low.
// [R3] Data drive enable is a level; data drivers are on only while it is high.
// [R4] During a processor read the data drivers stay off even with drive enable high.
// [R5] The outside system normally drives data drive enable from phase two.
// [R6] Another master owning the data bus holds data drive enable low meanwhile.
// [R7] Bus released is low when running and high once the processor stops and frees the bus.
// [R8] Bus released rises when the stop request is low or the core waits for an interrupt.
// [R9] While bus released is high every three-state driver is off and others are inactive.
// [R10] Waiting ends on a nonmaskable interrupt, or a maskable one while the mask flag is zero.
// [R11] Bus released is forced low while the float request is high.
// [R12] The clock source supplies two phases that are never high together.
// [R13] Direction reads high for reads, low for writes, and idles high.
// [R14] Direction floats on float request or halt; valid address is low on float request.
// [R15] While waiting with bus released high, valid address is low and all buses float.
`timescale 1ns/1ps
`include "mbdc_defs.svh"
`default_nettype none
module mbdc_bus_drive
    import mbdc_pkg::*;
#(
    parameter int ADDR_W = `MBDC_ADDR_W,
    parameter int DATA_W = `MBDC_DATA_W
) (
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              bus_float_request_i,
    input  wire logic              data_drive_enable_i,
    input  wire logic              stop_request_n_i,
    input  wire logic              nmi_n_i,
    input  wire logic              irq_n_i,
    input  wire logic              irq_mask_i,
    input  wire logic              idle_until_interrupt_op_i,
    input  wire logic [ADDR_W-1:0] core_addr_i,
    input  wire logic [DATA_W-1:0] core_wdata_i,
    input  wire logic              core_read_i,
    input  wire logic              core_valid_i,
    input  wire logic [DATA_W-1:0] data_lines_i,
    output logic [ADDR_W-1:0]      address_outputs_o,
    output logic                   address_outputs_oe_o,
    output logic [DATA_W-1:0]      data_lines_o,
    output logic                   data_lines_oe_o,
    output logic                   rw_o,
    output logic                   rw_oe_o,
    output logic                   valid_address_strobe_o,
    output logic                   bus_released_o,
    output logic [DATA_W-1:0]      core_rdata_o,
    output logic                   wake_o
);
    typedef struct packed {
        mbdc_mode_t        mode;
        logic              nmi_prev;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic              rw;
        logic              valid_address_strobe;
        logic              wake;
    } mbdc_state_t;
    mbdc_state_t st_reg;
    mbdc_state_t st_next;
    mbdc_sync_if sync ();
    logic nmi_edge;
    logic wake_cond;
    logic released;
    logic cycle_read;
    mbdc_pin_sync u_sync (
        .clk_i               (clk_i),
        .reset_i             (reset_i),
        .bus_float_request_i (bus_float_request_i),
        .data_drive_enable_i (data_drive_enable_i),
        .stop_request_n_i    (stop_request_n_i),
        .nmi_n_i             (nmi_n_i),
        .irq_n_i             (irq_n_i),
        .sync                (sync)
    );
    // NMI is edge sensitive, IRQ is a level gated by the mask
    assign nmi_edge  = st_reg.nmi_prev & ~sync.nmi_n;
    assign wake_cond = nmi_edge | (~sync.irq_n & ~irq_mask_i); // [R10]
    always_comb begin
        st_next = st_reg;
        st_next.nmi_prev = sync.nmi_n;
        st_next.wake = 1'b0;
        unique case (st_reg.mode)
            MBDC_RUN: begin
                if (!sync.stop_n) begin
                    st_next.mode = MBDC_HALTED; // [R8]
                end else if (idle_until_interrupt_op_i) begin
                    st_next.mode = MBDC_IDLE_WAIT; // [R8]
                end
            end
            MBDC_IDLE_WAIT: begin
                if (wake_cond && sync.stop_n) begin
                    st_next.mode = MBDC_RUN; // [R10]
                    st_next.wake = 1'b1;
                end
            end
            MBDC_HALTED: begin
                // Interrupts are not serviced while halted
                if (sync.stop_n) begin
                    st_next.mode = MBDC_RUN;
                end
            end
        endcase
        if (st_reg.mode == MBDC_RUN && sync.stop_n && !idle_until_interrupt_op_i
            && !sync.float_req) begin
            st_next.addr  = core_addr_i;
            st_next.wdata = core_wdata_i;
            st_next.rw    = (core_valid_i && !core_read_i) ? `MBDC_RW_WRITE
                                                           : `MBDC_RW_READ; // [R13]
            st_next.valid_address_strobe   = core_valid_i;
        end else begin
            st_next.rw  = `MBDC_RW_IDLE; // [R13]
            st_next.valid_address_strobe = 1'b0; // [R9] [R14] [R15]
        end
        if (st_reg.rw == `MBDC_RW_READ && st_reg.valid_address_strobe) begin
            st_next.rdata = data_lines_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_reg <= '{mode: MBDC_RUN, nmi_prev: 1'b1, addr: '0, wdata: '0, rdata: '0,
                        rw: 1'b1, valid_address_strobe: 1'b0, wake: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end
    // Float request overrides halt and wait indication
    assign released   = (st_reg.mode != MBDC_RUN) & ~sync.float_req; // [R7] [R8] [R11]
    assign cycle_read = (st_reg.rw == `MBDC_RW_READ);
    assign bus_released_o         = released;
    assign address_outputs_o      = st_reg.addr;
    assign address_outputs_oe_o   = ~sync.float_req & ~released; // [R1] [R9] [R15]
    assign rw_o                   = st_reg.rw;
    assign rw_oe_o                = ~sync.float_req & (st_reg.mode == MBDC_RUN); // [R14]
    // Drive enable gates drivers as a level; read cycles never drive
    assign data_lines_oe_o        = sync.drive_en & ~cycle_read & ~released; // [R2] [R3] [R4]
    assign data_lines_o           = st_reg.wdata;
    assign valid_address_strobe_o = st_reg.valid_address_strobe & ~sync.float_req; // [R14]
    assign core_rdata_o           = st_reg.rdata;
    assign wake_o                 = st_reg.wake;

    AST_FLOAT_ADDR: assert property (@(posedge clk_i) disable iff (reset_i) // [R1]
        sync.float_req |-> !address_outputs_oe_o && !rw_oe_o)
        else $error("address driven during float request");
    AST_DATA_OFF: assert property (@(posedge clk_i) disable iff (reset_i) // [R2]
        !sync.drive_en |-> !data_lines_oe_o)
        else $error("data driven with drive enable low");
    AST_DATA_ON: assert property (@(posedge clk_i) disable iff (reset_i) // [R3]
        sync.drive_en && !cycle_read && !released |-> data_lines_oe_o)
        else $error("data not driven during enabled write");
    AST_READ_OFF: assert property (@(posedge clk_i) disable iff (reset_i) // [R4]
        rw_o |-> !data_lines_oe_o)
        else $error("data driven during read");
    AST_HALT_REL: assert property (@(posedge clk_i) disable iff (reset_i) // [R8]
        !sync.stop_n && !sync.float_req |=> bus_released_o || sync.float_req)
        else $error("bus released missing after stop");
    AST_REL_OFF: assert property (@(posedge clk_i) disable iff (reset_i) // [R9] [R15]
        bus_released_o |-> !address_outputs_oe_o && !data_lines_oe_o && !rw_oe_o)
        else $error("driver on while bus released");
    AST_WAKE: assert property (@(posedge clk_i) disable iff (reset_i) // [R10]
        st_reg.mode == MBDC_IDLE_WAIT && wake_cond && sync.stop_n
        |=> st_reg.mode == MBDC_RUN && wake_o)
        else $error("wait state not left on interrupt");
    AST_FLOAT_REL: assert property (@(posedge clk_i) disable iff (reset_i) // [R11] [R14]
        sync.float_req |-> !bus_released_o && !valid_address_strobe_o)
        else $error("released or strobe high during float");
    AST_RUN_LOW: assert property (@(posedge clk_i) disable iff (reset_i) // [R7]
        st_reg.mode == MBDC_RUN |-> !bus_released_o)
        else $error("bus released high while running");
    AST_WAIT_VMA: assert property (@(posedge clk_i) disable iff (reset_i) // [R15]
        $past(st_reg.mode) != MBDC_RUN && st_reg.mode != MBDC_RUN |-> !valid_address_strobe_o)
        else $error("strobe high while stopped");
    AST_ADDR_ON: assert property (@(posedge clk_i) disable iff (reset_i) // [R1]
        !sync.float_req && !bus_released_o |-> address_outputs_oe_o)
        else $error("address not driven while running");
    AST_ADDR_HOLD: assert property (@(posedge clk_i) disable iff (reset_i) // [R1]
        sync.float_req |=> $stable(address_outputs_o))
        else $error("address moved during float request");
    AST_RW_IDLE: assert property (@(posedge clk_i) disable iff (reset_i) // [R13]
        !core_valid_i |=> rw_o)
        else $error("direction not idle high without a cycle");
    AST_RW_WRITE: assert property (@(posedge clk_i) disable iff (reset_i) // [R13]
        st_reg.mode == MBDC_RUN && sync.stop_n && !idle_until_interrupt_op_i
        && !sync.float_req && core_valid_i && !core_read_i |=> !rw_o)
        else $error("direction not low for a write");
    AST_RW_OE_ON: assert property (@(posedge clk_i) disable iff (reset_i) // [R13]
        !sync.float_req && st_reg.mode == MBDC_RUN |-> rw_oe_o)
        else $error("direction not driven while running");
    AST_HALT_RW: assert property (@(posedge clk_i) disable iff (reset_i) // [R14]
        st_reg.mode == MBDC_HALTED |-> !rw_oe_o)
        else $error("direction driven while halted");
    AST_FLOAT_IDLE: assert property (@(posedge clk_i) disable iff (reset_i) // [R14]
        $past(sync.float_req) |-> rw_o && !st_reg.valid_address_strobe)
        else $error("cycle launched during float request");
    AST_REL_ONLY: assert property (@(posedge clk_i) disable iff (reset_i) // [R7]
        bus_released_o |-> st_reg.mode != MBDC_RUN)
        else $error("bus released high without a stop");
    AST_WAIT_ENTRY: assert property (@(posedge clk_i) disable iff (reset_i) // [R8]
        st_reg.mode == MBDC_RUN && sync.stop_n && idle_until_interrupt_op_i
        |=> st_reg.mode == MBDC_IDLE_WAIT)
        else $error("wait state not entered");
    AST_WAIT_REL: assert property (@(posedge clk_i) disable iff (reset_i) // [R8] [R15]
        st_reg.mode == MBDC_IDLE_WAIT && !sync.float_req |-> bus_released_o)
        else $error("bus released low while waiting");
    AST_HALT_STAY: assert property (@(posedge clk_i) disable iff (reset_i) // [R8]
        st_reg.mode == MBDC_HALTED && !sync.stop_n |=> st_reg.mode == MBDC_HALTED)
        else $error("halt left while stop request low");
    AST_STOP_WAIT: assert property (@(posedge clk_i) disable iff (reset_i) // [R8]
        st_reg.mode == MBDC_IDLE_WAIT && !sync.stop_n |=> st_reg.mode != MBDC_RUN)
        else $error("wait left while stop request low");
    AST_WAIT_HOLD: assert property (@(posedge clk_i) disable iff (reset_i) // [R10]
        st_reg.mode == MBDC_IDLE_WAIT && !(wake_cond && sync.stop_n)
        |=> st_reg.mode == MBDC_IDLE_WAIT)
        else $error("wait state left without interrupt");
    AST_MASK_HOLD: assert property (@(posedge clk_i) disable iff (reset_i) // [R10]
        st_reg.mode == MBDC_IDLE_WAIT && !nmi_edge && irq_mask_i |=> !wake_o)
        else $error("masked request ended the wait");
    AST_NMI_WAKE: assert property (@(posedge clk_i) disable iff (reset_i) // [R10]
        st_reg.mode == MBDC_IDLE_WAIT && nmi_edge && sync.stop_n |=> wake_o)
        else $error("nonmaskable edge did not end the wait");
    AST_IRQ_WAKE: assert property (@(posedge clk_i) disable iff (reset_i) // [R10]
        st_reg.mode == MBDC_IDLE_WAIT && !sync.irq_n && !irq_mask_i && sync.stop_n |=> wake_o)
        else $error("unmasked request did not end the wait");
    AST_WAKE_PULSE: assert property (@(posedge clk_i) disable iff (reset_i) // [R10]
        wake_o |=> !wake_o)
        else $error("wake pulse longer than one cycle");
endmodule // mbdc_bus_drive
`default_nettype wire

//--- rtl/mbdc_defs.svh
// Shared constants for the bus drive control block
`ifndef MBDC_DEFS_SVH
`define MBDC_DEFS_SVH
`define MBDC_ADDR_W      16
`define MBDC_DATA_W      8
`define MBDC_RW_IDLE     1'b1
`define MBDC_RW_READ     1'b1
`define MBDC_RW_WRITE    1'b0
`define MBDC_SYNC_ZERO   3'h0
`define MBDC_SYNC_IDLE   5'h1C
`endif

//--- rtl/mbdc_pin_sync.sv
// Three-stage pin synchroniser for the bus control inputs
`timescale 1ns/1ps
`include "mbdc_defs.svh"
`default_nettype none
module mbdc_pin_sync (
    input  wire logic   clk_i,
    input  wire logic   reset_i,
    input  wire logic   bus_float_request_i,
    input  wire logic   data_drive_enable_i,
    input  wire logic   stop_request_n_i,
    input  wire logic   nmi_n_i,
    input  wire logic   irq_n_i,
    mbdc_sync_if.src    sync
);
    localparam int N = 5;
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] q;
    } mbdc_sync_t;
    mbdc_sync_t st_reg;
    mbdc_sync_t st_next;
    logic [N-1:0] pins;
    logic [N-1:0] idle_val;
    assign pins = {irq_n_i, nmi_n_i, stop_request_n_i, data_drive_enable_i, bus_float_request_i};
    assign idle_val = `MBDC_SYNC_IDLE;
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pins;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // Change accepted only once stages two and three agree
        for (int i = 0; i < N; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_reg <= '{s1: idle_val, s2: idle_val, s3: idle_val, q: idle_val};
        end else begin
            st_reg <= st_next;
        end
    end
    assign sync.float_req = st_reg.q[0];
    assign sync.drive_en  = st_reg.q[1];
    assign sync.stop_n    = st_reg.q[2];
    assign sync.nmi_n     = st_reg.q[3];
    assign sync.irq_n     = st_reg.q[4];
endmodule // mbdc_pin_sync
`default_nettype wire

//--- rtl/mbdc_pkg.sv
// Types for the bus drive control block
package mbdc_pkg;
    typedef enum logic [1:0] {
        MBDC_RUN,
        MBDC_IDLE_WAIT,
        MBDC_HALTED
    } mbdc_mode_t;
endpackage

//--- rtl/mbdc_sync_if.sv
// Synchronised control levels passed from the pin filter to the core
`timescale 1ns/1ps
`default_nettype none
interface mbdc_sync_if;
    logic float_req;
    logic drive_en;
    logic stop_n;
    logic nmi_n;
    logic irq_n;
    modport src (output float_req, output drive_en, output stop_n, output nmi_n, output irq_n);
    modport dst (input float_req, input drive_en, input stop_n, input nmi_n, input irq_n);
endinterface
`default_nettype wire

//--- verification/mbdc_mem_model.sv
// Memory side model that answers processor reads on the data lines
`timescale 1ns/1ps
`default_nettype none
module mbdc_mem_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] address_outputs_i,
    input  wire logic        rw_i,
    input  wire logic        valid_address_strobe_i,
    input  wire logic        data_lines_oe_i,
    output logic [7:0]       data_lines_o
);
    logic [7:0] junk_q = 8'h3C;
    // No pull-up on the data lines, so a released bus toggles
    always_ff @(posedge clk_i) begin
        junk_q <= ~junk_q;
    end
    // Drives only on a valid read while the processor drivers are off
    always_comb begin
        if (valid_address_strobe_i && rw_i && !data_lines_oe_i) begin
            data_lines_o = address_outputs_i[7:0] ^ 8'hA5;
        end else begin
            data_lines_o = junk_q;
        end
    end
endmodule // mbdc_mem_model
`default_nettype wire

//--- verification/test_mbdc_bus_drive.sv
// Self-checking bench for the bus drive control block
`timescale 1ns/1ps
`default_nettype none
module test_mbdc_bus_drive;
    logic clk_i = 0, reset_i = 1, flt = 0, den = 0, stop_n = 1, nmi_n = 1, irq_n = 1;
    logic mask = 1, idle_until_interrupt_op = 0, rd = 0, vld = 0;
    logic [15:0] addr = 16'h0000, a_o;
    logic [7:0] wd = 8'h00, d_o, d_mem, d_bus, rdat;
    logic a_oe, d_oe, rw, rw_oe, valid_address_strobe, rel, wake;
    int num_errors = 0, checks = 0;
    // One clock stands for both non-overlapping phases
    always #50 clk_i = ~clk_i;
    assign d_bus = d_oe ? d_o : d_mem;
    mbdc_bus_drive dut (.clk_i(clk_i), .reset_i(reset_i), .bus_float_request_i(flt),
        .data_drive_enable_i(den), .stop_request_n_i(stop_n), .nmi_n_i(nmi_n), .irq_n_i(irq_n),
        .irq_mask_i(mask), .idle_until_interrupt_op_i(idle_until_interrupt_op), .core_addr_i(addr),
        .core_wdata_i(wd), .core_read_i(rd), .core_valid_i(vld), .data_lines_i(d_bus),
        .address_outputs_o(a_o), .address_outputs_oe_o(a_oe), .data_lines_o(d_o),
        .data_lines_oe_o(d_oe), .rw_o(rw), .rw_oe_o(rw_oe), .valid_address_strobe_o(valid_address_strobe),
        .bus_released_o(rel), .core_rdata_o(rdat), .wake_o(wake));
    mbdc_mem_model mem (.clk_i(clk_i), .address_outputs_i(a_o), .rw_i(rw),
        .valid_address_strobe_i(valid_address_strobe), .data_lines_oe_i(d_oe), .data_lines_o(d_mem));
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic check_flag(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_wake();
        logic seen;
        seen = 0;
        for (int i = 0; i < 12 && !seen; i++) begin
            step(1);
            seen = (wake === 1'b1);
        end
        check_flag("wake", 1'b1, seen);
        step(1);
        check_flag("released after wake", 1'b0, rel);
    endtask
    task automatic t_transfers();
        den = 1; // Driven high on the processor's own data phase
        step(6);
        vld = 1; rd = 0; addr = 16'hF00D; wd = 8'h5A;
        step(1);
        check_word("write address", 16'hF00D, a_o);
        check_flag("write direction", 1'b0, rw);
        check_flag("write strobe", 1'b1, valid_address_strobe);
        check_flag("write data enable", 1'b1, d_oe);
        check_word("write data", {8'h00, 8'h5A}, {8'h00, d_o});
        check_flag("write address enable", 1'b1, a_oe);
        check_flag("write direction enable", 1'b1, rw_oe);
        check_flag("write released", 1'b0, rel);
        rd = 1; addr = 16'h1234;
        step(1);
        check_flag("read direction", 1'b1, rw);
        check_flag("read data enable", 1'b0, d_oe);
        vld = 0;
        step(1);
        check_word("read data", {8'h00, 8'h91}, {8'h00, rdat});
        den = 0; // Another master owns the data bus
        step(6);
        vld = 1; rd = 0;
        step(1);
        check_flag("data enable low", 1'b0, d_oe);
        vld = 0; den = 1;
        step(6);
        check_flag("idle direction", 1'b1, rw);
    endtask
    task automatic t_float_halt();
        flt = 1; vld = 1; rd = 0;
        step(6);
        check_flag("float address enable", 1'b0, a_oe);
        check_flag("float direction enable", 1'b0, rw_oe);
        check_flag("float strobe", 1'b0, valid_address_strobe);
        stop_n = 0;
        step(6);
        check_flag("float released", 1'b0, rel);
        flt = 0;
        step(6);
        check_flag("halt released", 1'b1, rel);
        check_flag("halt address enable", 1'b0, a_oe);
        check_flag("halt data enable", 1'b0, d_oe);
        check_flag("halt direction enable", 1'b0, rw_oe);
        check_flag("halt strobe", 1'b0, valid_address_strobe);
        stop_n = 1; vld = 0;
        step(6);
        check_flag("run released", 1'b0, rel);
    endtask
    task automatic t_wait();
        idle_until_interrupt_op = 1;
        step(1);
        idle_until_interrupt_op = 0;
        step(1);
        check_flag("wait released", 1'b1, rel);
        check_flag("wait strobe", 1'b0, valid_address_strobe);
        check_flag("wait address enable", 1'b0, a_oe);
        check_flag("wait direction enable", 1'b0, rw_oe);
        irq_n = 0;
        step(8);
        check_flag("masked irq held", 1'b1, rel);
        mask = 0;
        wait_wake();
        irq_n = 1; mask = 1; idle_until_interrupt_op = 1;
        step(1);
        idle_until_interrupt_op = 0;
        step(6);
        nmi_n = 0; // Edge wakes even with the mask set
        wait_wake();
        nmi_n = 1;
    endtask
    task automatic t_reset();
        idle_until_interrupt_op = 1;
        step(1);
        idle_until_interrupt_op = 0;
        reset_i = 1;
        step(2);
        reset_i = 0;
        check_flag("reset released", 1'b0, rel);
        check_flag("reset direction", 1'b1, rw);
        check_flag("reset strobe", 1'b0, valid_address_strobe);
        check_flag("reset data enable", 1'b0, d_oe);
        step(1);
        check_flag("reset address enable", 1'b1, a_oe);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #(400 * 100);
        num_errors++;
        report_and_stop();
    end
    initial begin
        step(12);
        reset_i = 0;
        t_transfers();
        t_float_halt();
        t_wait();
        t_reset();
        report_and_stop();
    end
endmodule // test_mbdc_bus_drive
`default_nettype wire
